// ===== rst_seq_pkg.sv
// Purpose: shared constants and carriers for the reset sequencer
// Assumes: 50 MHz clk, AHB-Lite word registers
// Notes:   offsets chosen for this block
package rst_seq_pkg;
  // ***********************************************
  // register byte offsets
  // ***********************************************
  localparam logic [11:0] OFS_WDCTRL  = 12'h000; // cause flags and watchdog control
  localparam logic [11:0] OFS_LPCTRL  = 12'h004; // low-power control
  localparam logic [11:0] OFS_CLKSEL  = 12'h008; // clock selection
  localparam logic [11:0] OFS_SEQSTAT = 12'h00C; // sequence status and vector
  // ***********************************************
  // fetch addresses and mode pins
  // ***********************************************
  localparam logic [23:0] ADDR_MODE   = 24'hFFFFDF; // mode byte
  localparam logic [23:0] ADDR_VEC0   = 24'hFFFFDC; // vector low byte
  localparam logic [23:0] ADDR_VEC2   = 24'hFFFFDE; // vector bank byte
  localparam logic [2:0]  MODE_INTVEC = 3'h6;       // internal vector mode, 110B
  // ***********************************************
  // field positions
  // ***********************************************
  localparam int BIT_PON  = 7;  // power-on cause
  localparam int BIT_STB  = 6;  // standby release cause
  localparam int BIT_WDG  = 5;  // watchdog cause
  localparam int BIT_EXT  = 4;  // external pin cause
  localparam int BIT_SW   = 3;  // software cause
  localparam int BIT_WTE  = 2;  // watchdog enable
  localparam int BIT_MCS  = 10; // machine clock select in clock selection register
  localparam int BIT_WATCHDOG_CLOCK_SOURCE = 11; // watchdog clock source
  localparam int BIT_SOFTWARE_CAUSE_FLAG = 4;  // software reset bit in low-power control
  // ***********************************************
  // reset values and timing
  // ***********************************************
  localparam logic [1:0] WS_LONGEST = 2'h3; // longest oscillation wait
  localparam logic [1:0] CS_TIMES1  = 2'h0; // pll multiplier one
  localparam logic [1:0] CG_NONE    = 2'h0; // no cpu pause cycles
  localparam int SW_PULSE_CYC = 3;          // software reset pulse, machine cycles
  localparam logic [1:0] SW_PULSE_LAST = 2'(SW_PULSE_CYC - 1);
  localparam int SEG_COUNT = 8;             // display segment pins

  typedef enum logic [2:0] {S_IDLE, S_HOLD, S_MODE, S_V0, S_V1, S_V2, S_DONE} seq_e;

  // ahb request carrier
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
  } ahb_req_s;

  // reset sources, one bit each
  typedef struct packed {
    logic pon;
    logic stb;
    logic wdg;
    logic ext;
    logic sw;
  } rst_src_s;
endpackage

// ===== rom_byte_reg.sv
// Purpose: registered byte capture for rom fetch data
// Assumes: rom answers one cycle after address
// Notes:   holds last fetched bytes for the sequencer
`timescale 1ns/1ps
`default_nettype none
module rom_byte_reg (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // capture
  input  wire logic        load,
  input  wire logic [1:0]  slot,
  input  wire logic [7:0]  din,
  // registered words
  output logic      [31:0] dout
);
  // ***********************************************
  // byte slots
  // ***********************************************
  // each slot loads only when selected
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      dout <= 32'h0000_0000;
    else if (load)
      dout[slot*8 +: 8] <= din;
  end
endmodule
`default_nettype wire

// ===== reset_sequence_and_cause_flags.sv
// Purpose: reset sequencing, cause flags and reset-initialised control bits
// Assumes: 50 MHz clk, sync active-high sys_rst is the power-on reset
// Notes:   registers over AHB-Lite, zero wait states
//
// Local design decisions: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module reset_sequence_and_cause_flags
  import rst_seq_pkg::*;
(
  // clock and reset
  input  wire logic                clk,
  input  wire logic                sys_rst,
  // ahb-lite slave
  input  wire rst_seq_pkg::ahb_req_s ahbReq,
  input  wire logic [31:0]         hwdata,
  output logic [31:0]              hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  // board pins, asynchronous
  input  wire logic [2:0]          mode_select_pins,
  input  wire logic                resetPinN,
  input  wire logic                hardware_standby_pin,
  // internal reset source and oscillator status
  input  wire logic                watchdogOverflow,
  input  wire logic                oscStable,
  // rom fetch port
  output logic [23:0]              romAddr,
  output logic                     romRead,
  input  wire logic [7:0]          romData,
  // cpu side
  output logic                     cpuRun,
  output logic [7:0]               memory_access_mode_bits,
  output logic [23:0]              startVector,
  output logic                     vectorLoad,
  // pin state control
  output logic                     ioOutEnable,
  output logic                     ioInEnable,
  output logic [SEG_COUNT-1:0]     display_segment_outputs,
  // clock and watchdog controls
  output logic                     pllSelected,
  output logic                     watchTimerSrc,
  output logic [1:0]               oscWaitSel,
  output logic [1:0]               pllMulSel,
  output logic [1:0]               cpuPauseSel,
  output logic                     watchdogEnable,
  output logic [1:0]               watchdogInterval
);
  // ***********************************************
  // pin synchronisers
  // ***********************************************
  logic [2:0] modeMeta;     // first stage, read only by second
  logic [2:0] modeSync;     // synchronised mode pins
  logic [1:0] rstMeta;      // first stage for reset and standby pins
  logic [1:0] rstSync;      // {standby, resetN} synchronised
  logic       stbPrev;      // standby level last cycle

  // two flops on every board pin
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      modeMeta <= 3'h0;
      modeSync <= 3'h0;
      rstMeta  <= 2'h3;
      rstSync  <= 2'h3;
      stbPrev  <= 1'b1;
    end
    else
    begin
      modeMeta <= mode_select_pins;
      modeSync <= modeMeta;
      rstMeta  <= {hardware_standby_pin, resetPinN};
      rstSync  <= rstMeta;
      stbPrev  <= rstSync[1];
    end
  end

  // ***********************************************
  // reset source detection
  // ***********************************************
  rst_src_s src;            // this cycle's reset events
  logic     swPulse;        // software reset pulse active
  logic [1:0] swCnt;        // pulse length counter
  logic     swReq;          // software reset bit written 0
  logic     ponSeen;        // power-on pending capture

  // power-on is sys_rst itself; the flag is set at the first cycle after it
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ponSeen <= 1'b1;
    else
      ponSeen <= 1'b0;
  end

  // standby release is the low to high edge; ext is a held low pin
  always_comb
  begin
    src.pon = ponSeen;
    src.stb = rstSync[1] && !stbPrev;
    src.wdg = watchdogOverflow;
    src.ext = !rstSync[0];
    src.sw  = swReq;
  end

  // software reset pulse lasts three machine cycles
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      swPulse <= 1'b0;
      swCnt   <= 2'h0;
    end
    else if (swReq)
    begin
      swPulse <= 1'b1;
      swCnt   <= 2'h0;
    end
    else if (swPulse)
    begin
      if (swCnt == SW_PULSE_LAST)
        swPulse <= 1'b0;
      swCnt <= swCnt + 2'h1;
    end
  end

  // ***********************************************
  // bus slave
  // ***********************************************
  logic        wrPend;      // write data phase pending
  logic        rdPend;      // read data phase pending
  logic [11:0] phAddr;      // latched address phase
  logic        takeAddr;    // valid address phase this cycle

  assign takeAddr = ahbReq.hsel && ahbReq.htrans[1] && ahbReq.hready;

  // zero-wait slave: latch address phase, act in data phase
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wrPend <= 1'b0;
      rdPend <= 1'b0;
      phAddr <= 12'h000;
    end
    else
    begin
      wrPend <= takeAddr && ahbReq.hwrite;
      rdPend <= takeAddr && !ahbReq.hwrite;
      if (takeAddr)
        phAddr <= ahbReq.haddr[11:0];
    end
  end

  // always ready, always okay
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  assign swReq = wrPend && (phAddr == OFS_LPCTRL) && !hwdata[BIT_SOFTWARE_CAUSE_FLAG];

  // ***********************************************
  // cause flags
  // ***********************************************
  logic [4:0] causeFlags;   // {pon, stb, wdg, ext, sw}
  logic       flagRead;     // read data phase of flag register

  // read data is sampled from registers at address phase, so the clear
  // lands in the data phase after the value was captured
  assign flagRead = rdPend && (phAddr == OFS_WDCTRL);

  // set wins over clear so an event during a read survives
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      causeFlags <= 5'h00;
    else if (src.pon)
      causeFlags <= 5'h10;
    else
      // only the bits handed out in hrdata are cleared, so an event caught
      // on the address-phase edge is not lost
      causeFlags <= (flagRead ? (causeFlags & ~hrdata[7:3]) : causeFlags)
                    | {1'b0, src.stb, src.wdg, src.ext, src.sw};
  end

  // ***********************************************
  // control registers
  // ***********************************************
  logic fullInit;           // pon, standby or watchdog
  assign fullInit = src.pon || src.stb || src.wdg;

  // watchdog control bits, write only
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      watchdogEnable   <= 1'b0;
      watchdogInterval <= 2'h0;
    end
    else if (fullInit)
      watchdogEnable <= 1'b0;
    else if (wrPend && phAddr == OFS_WDCTRL)
    begin
      watchdogEnable   <= hwdata[BIT_WTE];
      watchdogInterval <= hwdata[1:0];
    end
  end

  // clock selection; sw and pin resets touch nothing here
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      oscWaitSel    <= WS_LONGEST;
      pllMulSel     <= CS_TIMES1;
      pllSelected   <= 1'b0;
      watchTimerSrc <= 1'b0;
    end
    else if (src.stb || src.wdg)
      pllSelected <= 1'b0;
    else if (wrPend && phAddr == OFS_CLKSEL)
    begin
      oscWaitSel    <= hwdata[9:8];
      pllMulSel     <= hwdata[1:0];
      pllSelected   <= !hwdata[BIT_MCS];
      watchTimerSrc <= !hwdata[BIT_WATCHDOG_CLOCK_SOURCE];
    end
  end

  // cpu pause cycles in low-power control
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      cpuPauseSel <= CG_NONE;
    else if (fullInit)
      cpuPauseSel <= CG_NONE;
    else if (wrPend && phAddr == OFS_LPCTRL)
      cpuPauseSel <= hwdata[7:6];
  end

  // ***********************************************
  // reset sequence
  // ***********************************************
  seq_e       state;        // sequencer state
  logic       needWait;     // oscillation wait required
  logic       anyReset;     // some reset held this cycle
  logic [7:0] modeShadow;   // mode byte, valid only in sequence
  logic [31:0] fetched;     // registered rom bytes
  logic       capLoad;      // capture rom byte
  logic [1:0] capSlot;      // which byte slot
  logic       seqEnd;       // fetch pipeline drained in done state

  assign anyReset = src.stb || src.wdg || src.ext || swPulse || swReq;
  assign seqEnd   = (state == S_DONE) && !romRead && !capLoad;

  // walks mode byte then three vector bytes; one rom cycle each
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state    <= S_HOLD;
      needWait <= 1'b1;
    end
    else if (anyReset)
    begin
      state    <= S_HOLD;
      // a wait owed by an earlier source survives a later pin reset
      needWait <= src.stb || src.wdg || (needWait && state == S_HOLD);
    end
    else
    begin
      case (state)
        S_HOLD:
          if (!needWait || oscStable)
            state <= (modeSync == MODE_INTVEC) ? S_MODE : S_HOLD;
        S_MODE:  state <= S_V0;
        S_V0:    state <= S_V1;
        S_V1:    state <= S_V2;
        S_V2:    state <= S_DONE;
        S_DONE:  state <= seqEnd ? S_IDLE : S_DONE;
        default: state <= S_IDLE;
      endcase
    end
  end

  // rom address per state, registered one cycle ahead of capture
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      romAddr <= 24'h000000;
      romRead <= 1'b0;
      capLoad <= 1'b0;
      capSlot <= 2'h0;
    end
    else
    begin
      romRead <= (state == S_MODE) || (state == S_V0) || (state == S_V1)
                 || (state == S_V2);
      capLoad <= romRead;
      capSlot <= 2'(romAddr[1:0] + 2'h1);
      case (state)
        S_MODE:  romAddr <= ADDR_MODE;
        S_V0:    romAddr <= ADDR_VEC0;
        S_V1:    romAddr <= ADDR_VEC0 + 24'h000001;
        S_V2:    romAddr <= ADDR_VEC2;
        default: romAddr <= romAddr;
      endcase
    end
  end

  rom_byte_reg uFetch (
    .clk     (clk),
    .sys_rst (sys_rst),
    .load    (capLoad),
    .slot    (capSlot),
    .din     (romData),
    .dout    (fetched)
  );

  // mode byte lands in slot 0 (address ...DF wraps), vector in 1..3
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      modeShadow <= 8'h00;
    else if (state != S_IDLE)
      modeShadow <= fetched[7:0];
  end

  // cpu sees mode and vector only after the sequence ends
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      memory_access_mode_bits <= 8'h00;
      startVector             <= 24'h000000;
      vectorLoad              <= 1'b0;
      cpuRun                  <= 1'b0;
    end
    else
    begin
      vectorLoad <= seqEnd;
      if (seqEnd)
      begin
        memory_access_mode_bits <= modeShadow;
        startVector             <= fetched[31:8];
      end
      cpuRun <= (state == S_IDLE);
    end
  end

  // ***********************************************
  // pin states during reset
  // ***********************************************
  // held off until the vector is in, so nothing glitches mid-sequence
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ioOutEnable             <= 1'b0;
      ioInEnable              <= 1'b0;
      display_segment_outputs <= '0;
    end
    else
    begin
      ioOutEnable             <= (state == S_IDLE);
      ioInEnable              <= (state == S_IDLE);
      display_segment_outputs <= '0;
    end
  end

  // ***********************************************
  // read mux
  // ***********************************************
  // captured at address phase; flags then clear in the data phase
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      hrdata <= 32'h0000_0000;
    else if (takeAddr && !ahbReq.hwrite)
    begin
      if (ahbReq.haddr[11:0] == OFS_WDCTRL)
        hrdata <= {24'h0, causeFlags, 3'h0};
      else if (ahbReq.haddr[11:0] == OFS_LPCTRL)
        hrdata <= {24'h0, cpuPauseSel, 6'h10};
      else if (ahbReq.haddr[11:0] == OFS_CLKSEL)
        hrdata <= {20'h0, !watchTimerSrc, !pllSelected, oscWaitSel, 6'h0, pllMulSel};
      else if (ahbReq.haddr[11:0] == OFS_SEQSTAT)
        hrdata <= {cpuRun, 7'h0, startVector};
      else
        hrdata <= 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// ===== reset_seq_chk.sv
// Purpose: port-level assertions for the reset sequencer
// Assumes: one clock domain, sys_rst synchronous active high
// Notes:   bound into every sequencer instance below
`timescale 1ns/1ps
`default_nettype none
module reset_seq_chk
  import rst_seq_pkg::*;
(
  // clock and reset
  input wire logic                 clk,
  input wire logic                 sys_rst,
  // reset causes and rom fetch
  input wire logic                 watchdogOverflow,
  input wire logic                 romRead,
  input wire logic [23:0]          romAddr,
  // cpu side
  input wire logic                 cpuRun,
  input wire logic                 vectorLoad,
  input wire logic [7:0]           memory_access_mode_bits,
  input wire logic [23:0]          startVector,
  // pins and controls
  input wire logic                 ioOutEnable,
  input wire logic                 ioInEnable,
  input wire logic [SEG_COUNT-1:0] display_segment_outputs,
  input wire logic                 pllSelected,
  input wire logic [1:0]           cpuPauseSel,
  input wire logic                 watchdogEnable
);
  // ****************
  // assertions
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // segments low whenever the cpu is held
  AST_SEG_LOW: assert property (!cpuRun |-> display_segment_outputs == '0)
    else $error("segment pins driven while held");
  // two held cycles, though the enable registers switch on the same edge as cpuRun
  AST_IO_OFF: assert property (!cpuRun [*2] |-> !ioOutEnable && !ioInEnable)
    else $error("io enabled while held");
  AST_FETCH_HELD: assert property (romRead |-> !cpuRun)
    else $error("rom fetch while running");
  AST_MODE_FETCH: assert property (romRead && romAddr == ADDR_MODE |-> ##[1:8] vectorLoad)
    else $error("mode fetch not followed by vector load");
  AST_RUN_AFTER_LOAD: assert property (vectorLoad |-> ##[0:2] cpuRun)
    else $error("cpu not started after vector load");
  AST_LOAD_PULSE: assert property (vectorLoad |=> !vectorLoad)
    else $error("vector load longer than one cycle");
  AST_MODE_HELD: assert property (cpuRun && $past(cpuRun)
    |-> $stable(memory_access_mode_bits) && $stable(startVector))
    else $error("mode or vector changed while running");
  AST_WDG_STOP: assert property (watchdogOverflow |-> ##[1:4] !watchdogEnable)
    else $error("watchdog not stopped by its reset");
  AST_WDG_MAIN: assert property (watchdogOverflow |-> ##[1:4] !pllSelected)
    else $error("main clock not selected after watchdog reset");
  AST_WDG_PAUSE: assert property (watchdogOverflow |-> ##[1:4] cpuPauseSel == CG_NONE)
    else $error("pause cycles kept after watchdog reset");
  // main scenarios
  cover property (vectorLoad);
  cover property (watchdogOverflow);
  cover property ($fell(cpuRun));
endmodule

bind reset_sequence_and_cause_flags reset_seq_chk chk_u (
  .clk(clk),
  .sys_rst(sys_rst),
  .watchdogOverflow(watchdogOverflow),
  .romRead(romRead),
  .romAddr(romAddr),
  .cpuRun(cpuRun),
  .vectorLoad(vectorLoad),
  .memory_access_mode_bits(memory_access_mode_bits),
  .startVector(startVector),
  .ioOutEnable(ioOutEnable),
  .ioInEnable(ioInEnable),
  .display_segment_outputs(display_segment_outputs),
  .pllSelected(pllSelected),
  .cpuPauseSel(cpuPauseSel),
  .watchdogEnable(watchdogEnable)
);
`default_nettype wire

// ===== board_model.sv
// Purpose: board pins and boot rom seen by the reset sequencer
// Assumes: rom byte answered the cycle after the fetch strobe
// Notes:   rom data wanders when not fetched
`timescale 1ns/1ps
`default_nettype none
module board_model #(
  parameter logic [23:0] VEC  = 24'h000000, // reset vector in rom
  parameter logic [7:0]  MODE = 8'h00       // mode byte in rom
) (
  // clock
  input  wire logic        clk,
  // bench controls
  input  wire logic [2:0]  modeSet,
  input  wire logic        pinLow,
  input  wire logic        stbyHigh,
  input  wire logic        tieStby,
  // board pins
  output logic      [2:0]  mode_select_pins,
  output logic             resetPinN,
  output logic             hardware_standby_pin,
  // rom port
  input  wire logic        romRead,
  input  wire logic [23:0] romAddr,
  output logic      [7:0]  romData
);
  logic [7:0] junk = 8'hA5; // changing filler, stepping through every byte value, so a stale byte only matches a valid one by chance
  assign mode_select_pins = modeSet;
  assign resetPinN = !pinLow;
  // shorted standby and reset pins make a pin reset also a standby release
  assign hardware_standby_pin = tieStby ? !pinLow : stbyHigh;
  // rom: mode byte on top of the three vector bytes
  always_ff @(posedge clk)
  begin
    junk <= junk + 8'h5B;
    if (romRead)
      romData <= 8'({MODE, VEC} >> {romAddr[1:0], 3'h0});
    else
      romData <= junk;
  end
endmodule
`default_nettype wire

// ===== test_reset_sequence_and_cause_flags.sv
// Purpose: self-checking bench for the reset sequencer
// Assumes: zero-wait AHB-Lite slave, 50 MHz clock
// Notes:   reads queue expectations, a monitor compares them
`timescale 1ns/1ps
`default_nettype none
module test_reset_sequence_and_cause_flags;
  import rst_seq_pkg::*;
  localparam logic [23:0] VEC  = 24'h3A5C71; // arbitrary start address
  localparam logic [7:0]  MODE = 8'h2D;      // arbitrary mode byte
  logic        clk = 1'h0;
  logic        sys_rst = 1'h1;
  ahb_req_s    req = '0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, resetPinN, hardware_standby_pin, romRead, cpuRun;
  logic        vectorLoad, ioOutEnable, ioInEnable, pllSelected, watchTimerSrc;
  logic        watchdogEnable;
  logic [1:0]  oscWaitSel, pllMulSel, cpuPauseSel, watchdogInterval;
  logic [2:0]  mode_select_pins;
  logic [7:0]  romData, memory_access_mode_bits, display_segment_outputs;
  logic [23:0] romAddr, startVector;
  logic [2:0]  modeSet = 3'h0;
  logic        pinLow = 1'h0, stbyHigh = 1'h1, tieStby = 1'h0;
  logic        watchdogOverflow = 1'h0, oscStable = 1'h0, dPend = 1'h0;
  logic [31:0] rnd = 32'h27C3B263;
  logic [31:0] expQ[$], mskQ[$];
  int          num_errors = 0, n_compared = 0, cyc = 0;

  reset_sequence_and_cause_flags dut_u (
    .clk(clk), .sys_rst(sys_rst),
    .ahbReq({req[$bits(req)-1:1], hreadyout}),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .mode_select_pins(mode_select_pins), .resetPinN(resetPinN),
    .hardware_standby_pin(hardware_standby_pin),
    .watchdogOverflow(watchdogOverflow), .oscStable(oscStable),
    .romAddr(romAddr), .romRead(romRead), .romData(romData),
    .cpuRun(cpuRun), .memory_access_mode_bits(memory_access_mode_bits),
    .startVector(startVector), .vectorLoad(vectorLoad),
    .ioOutEnable(ioOutEnable), .ioInEnable(ioInEnable),
    .display_segment_outputs(display_segment_outputs),
    .pllSelected(pllSelected), .watchTimerSrc(watchTimerSrc),
    .oscWaitSel(oscWaitSel), .pllMulSel(pllMulSel), .cpuPauseSel(cpuPauseSel),
    .watchdogEnable(watchdogEnable), .watchdogInterval(watchdogInterval)
  );
  board_model #(.VEC(VEC), .MODE(MODE)) board_u (
    .clk(clk), .modeSet(modeSet), .pinLow(pinLow), .stbyHigh(stbyHigh),
    .tieStby(tieStby), .mode_select_pins(mode_select_pins),
    .resetPinN(resetPinN), .hardware_standby_pin(hardware_standby_pin),
    .romRead(romRead), .romAddr(romAddr), .romData(romData)
  );

  // ****************
  // helpers
  // ****************
  initial
  begin
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one single word transfer; a read queues its masked expectation
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic [31:0] m);
    if (!wr)
    begin
      expQ.push_back(e & m);
      mskQ.push_back(m);
    end
    req.hsel <= 1'h1;
    req.haddr <= {20'h0, a};
    req.htrans <= 2'h2;
    req.hwrite <= wr;
    req.hsize <= 3'h2;
    do @(posedge clk); while (hreadyout !== 1'h1);
    req.hsel <= 1'h0;
    req.htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'h1);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    bus(1'h0, a, 32'h0, e, m);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'h1, a, d, 32'h0, 32'h0);
  endtask
  task automatic waitRun(input logic lvl);
    while (cpuRun !== lvl)
      @(posedge clk);
  endtask
  // monitor: compare each read data phase with the oldest note
  always @(posedge clk)
  begin
    if (dPend && hreadyout === 1'h1)
      check(hrdata & mskQ.pop_front(), expQ.pop_front());
    if (hreadyout === 1'h1)
      dPend <= req.hsel && req.htrans[1] && !req.hwrite;
  end
  // hang guard, well above the couple of hundred cycles needed
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      num_errors++;
      summarize();
    end
  end

  // ****************
  // scenarios
  // ****************
  initial
  begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'h0;
    oscStable <= 1'h1;
    repeat (20) @(posedge clk);
    check(32'(cpuRun), 32'h0);
    check(32'({ioOutEnable, ioInEnable, display_segment_outputs}), 32'h0);
    modeSet <= MODE_INTVEC;
    waitRun(1'h1);
    rd(OFS_SEQSTAT, {8'h80, VEC}, 32'hFFFFFFFF);
    check(32'(memory_access_mode_bits), 32'(MODE));
    rd(OFS_WDCTRL, 32'h80, 32'h80);
    rd(OFS_WDCTRL, 32'h0, 32'hF8);
    rd(OFS_CLKSEL, 32'h0700, 32'h0703);
    rd(OFS_LPCTRL, 32'h0, 32'hC0);
    check(32'({pllSelected, ioInEnable}), 32'h1);
    $display("test power-on sequence done");
    wr(OFS_CLKSEL, 32'h0902);
    rd(OFS_CLKSEL, 32'h0902, 32'h0F03);
    check(32'({pllSelected, watchTimerSrc}), 32'h2);
    rnd = xs(rnd);
    wr(OFS_WDCTRL, {24'h0, 6'h3F, rnd[1:0]});
    wr(OFS_LPCTRL, 32'hD0);
    @(posedge clk);
    check(32'({watchdogEnable, watchdogInterval, cpuPauseSel}), 32'({1'h1, rnd[1:0], 2'h3}));
    rd(OFS_WDCTRL, 32'h0, 32'hF8);
    rd(12'h010, 32'h0, 32'hFFFFFFFF);
    $display("test register access done");
    oscStable <= 1'h0; // software reset must not wait for it
    wr(OFS_LPCTRL, 32'hC0);
    waitRun(1'h0);
    waitRun(1'h1);
    rd(OFS_WDCTRL, 32'h08, 32'hF8);
    rd(OFS_CLKSEL, 32'h0902, 32'h0F03);
    check(32'(watchdogEnable), 32'h1);
    $display("test software reset done");
    oscStable <= 1'h1;
    rnd = xs(rnd);
    pinLow <= 1'h1;
    repeat (4) @(posedge clk);
    watchdogOverflow <= 1'h1;
    @(posedge clk);
    watchdogOverflow <= 1'h0;
    repeat (12 + rnd[3:0]) @(posedge clk);
    check(32'({cpuRun, ioOutEnable, display_segment_outputs}), 32'h0);
    pinLow <= 1'h0;
    waitRun(1'h1);
    rd(OFS_WDCTRL, 32'h30, 32'hF8);
    rd(OFS_CLKSEL, 32'h0502, 32'h0703);
    rd(OFS_LPCTRL, 32'h0, 32'hC0);
    check(32'(watchdogEnable), 32'h0);
    $display("test pin and watchdog reset done");
    tieStby <= 1'h1;
    wr(OFS_CLKSEL, 32'h0102);
    pinLow <= 1'h1;
    repeat (20) @(posedge clk);
    pinLow <= 1'h0;
    waitRun(1'h1);
    rd(OFS_WDCTRL, 32'h50, 32'hF8);
    rd(OFS_CLKSEL, 32'h0502, 32'h0703);
    $display("test tied standby reset done");
    summarize();
  end
endmodule
`default_nettype wire
